/* File: hdl/readout_supervisor_regs.svh */
// Functional notes
// - readout limit 0..16 selects 1 s to 17 s
// - time from full trigger ack to release
// - busy unit at expiry halts acquisition
// - restart command clears errors, resumes operation
// - generator, builder, mover states read only
// - pedestal variable: standby 0x0, busy 0x1
// - end of pedestal event returns standby
// - slow-control states 0x0 through 0x5
// - data-taking states 0x0 through 0x8
// - three state variables readable and writable
`ifndef READOUT_SUPERVISOR_REGS_SVH
`define READOUT_SUPERVISOR_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define REG_CONTROL 8'h00
`define REG_MAX_TIME 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0c
`define REG_FSM_STATES 8'h10
`define REG_SLOW_CONTROL 8'h14
`define REG_DATA_TAKING 8'h18
`define REG_PEDESTAL 8'h1c
`define REG_CARD_ACTIVE 8'h20
`define REG_UNIT_ACTIVE 8'h24
`define REG_MONITOR 8'h28

// ****************************************************************
// fields
// ****************************************************************
`define CTRL_RESTART_BIT 0
`define IRQ_TIMEOUT_BIT 0
`define IRQ_PED_DONE_BIT 1
`define IRQ_WIDTH 2
`define MAX_TIME_LIMIT 5'h10
`define MAX_TIME_RESET 5'h10
`define MON_HALT_BIT 0
`define MON_TIMING_BIT 1
`define MON_ARMED_BIT 2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_FREQ_HZ 100000000
`define STEP_TIME_S 1
`define STEP_CYCLES (`STEP_TIME_S * `CLK_FREQ_HZ)

`endif

/* File: hdl/readout_pkg.sv */
package readout_pkg;

  // slow-control state codes, in documented order
  typedef enum logic [3:0] {
    power_on_default_a,
    configuring,
    config_failed,
    config_success,
    monitor_running_b,
    monitor_paused_c
  } slow_control_e;

  // data-taking state codes, in documented order
  typedef enum logic [3:0] {
    take_power_on_default,
    waiting_for_slow_control,
    take_configuring,
    take_config_failed,
    take_config_success,
    take_running,
    take_paused,
    take_stopped,
    take_disconnected
  } data_taking_e;

  typedef enum logic {
    ped_standby,
    ped_busy
  } pedestal_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

/* File: hdl/readout_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module readout_timer #(
  parameter int CYCLES_PER_STEP = 100000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [4:0] limit,
  output logic running,
  output logic expired
);

  localparam int PW = $clog2(CYCLES_PER_STEP);

  // a one-cycle step leaves the prescaler no room to count
  if (CYCLES_PER_STEP < 2) begin : bad_step
    $error("readout_timer: CYCLES_PER_STEP must be at least 2");
  end

  logic [PW-1:0] presc;
  logic [4:0] steps;

  // ****************************************************************
  // step counter: limit+1 whole steps before expiry
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
      presc <= '0;
      steps <= 5'h00;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        running <= 1'b1;
        presc <= '0;
        steps <= 5'h00;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (presc == PW'(CYCLES_PER_STEP - 1)) begin
          presc <= '0;
          // at or past the limit, so a limit lowered mid-count still ends it
          if (steps >= limit) begin
            expired <= 1'b1;
            running <= 1'b0;
          end else begin
            steps <= steps + 5'h01;
          end
        end else begin
          presc <= presc + PW'(1);
        end
      end
    end
  end

  chk_steps_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    running && !start && !stop && presc == PW'(CYCLES_PER_STEP - 1) && steps >= limit
    |=> expired) else $error("no expiry at the step limit");

  chk_expiry_stops: assert property (@(posedge pclk) disable iff (!presetn)
    expired |-> !running && $past(running)) else $error("expiry without a run");

endmodule
`default_nettype wire

/* File: hdl/irq_status.sv */
`timescale 1ns/100ps
`default_nettype none
module irq_status #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] event_set,
  input wire logic [W-1:0] clear_ones,
  input wire logic mask_we,
  input wire logic [W-1:0] mask_wdata,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  // a status word wider than one bus word could not be read back
  if (W < 1 || W > 32) begin : bad_width
    $error("irq_status: W must be 1 to 32");
  end

  // sticky bits: a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~clear_ones) | event_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (mask_we) begin
      mask <= mask_wdata;
    end
  end

  // level output, registered so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~clear_ones) | event_set) & (mask_we ? mask_wdata : mask));
    end
  end

  chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status & mask)) else $error("irq level disagrees with status");

endmodule
`default_nettype wire

/* File: hdl/readout_timeout_state_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "readout_supervisor_regs.svh"
module readout_timeout_state_supervisor #(
  parameter int N_CARDS = 8,
  parameter int N_UNITS = 8,
  parameter int CYCLES_PER_STEP = `STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire readout_pkg::apb_req_s apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic trigger_sent,
  input wire logic [N_CARDS-1:0] front_end_card_ack,
  input wire logic [N_UNITS-1:0] front_end_unit_clear_busy,
  input wire logic pedestal_event_done,
  input wire logic [7:0] trigger_generator_state,
  input wire logic [7:0] event_builder_state,
  input wire logic [7:0] packet_mover_state,
  output logic acq_halt,
  output logic error_restart_command,
  output logic irq
);

  // elaboration stops here for counts that one 32-bit register cannot hold
  if (N_CARDS < 1 || N_CARDS > 32 || N_UNITS < 1 ||
      N_UNITS > 32) begin : bad_counts
    $error("supervisor: card and unit counts must be 1 to 32");
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic wr_en;
  logic rd_take;
  logic [31:0] wd;
  logic [7:0] addr;

  assign addr = apb_req.paddr;
  assign wd = apb_req.pwdata;
  // a write lands only at the edge that completes the access
  assign wr_en = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  assign rd_take = apb_req.psel & apb_req.penable & ~pready & ~apb_req.pwrite;

  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      `REG_CONTROL, `REG_MAX_TIME, `REG_IRQ_STATUS, `REG_IRQ_MASK,
      `REG_FSM_STATES, `REG_SLOW_CONTROL, `REG_DATA_TAKING, `REG_PEDESTAL,
      `REG_CARD_ACTIVE, `REG_UNIT_ACTIVE, `REG_MONITOR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] r);
    wr_hit = en && (a == r);
  endfunction

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_req.psel & apb_req.penable & ~pready;
      pslverr <= apb_req.psel & apb_req.penable & ~pready & ~is_mapped(addr);
    end
  end

  // ****************************************************************
  // software state variables
  // ****************************************************************
  logic [4:0] max_time;
  logic [3:0] slow_control_state;
  logic [3:0] data_taking_state;
  logic pedestal_accumulator_state;
  logic [N_CARDS-1:0] card_active;
  logic [N_UNITS-1:0] unit_active;

  // settings 0x11 to 0x1f clamp to the longest timeout; bits above bit 4 are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_time <= `MAX_TIME_RESET;
    end else if (wr_hit(wr_en, addr, `REG_MAX_TIME)) begin
      max_time <= (wd[4:0] > `MAX_TIME_LIMIT) ? `MAX_TIME_LIMIT : wd[4:0];
    end
  end

  // raw writes let software signal any condition it needs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_control_state <= readout_pkg::power_on_default_a;
      data_taking_state <= readout_pkg::take_power_on_default;
    end else begin
      if (wr_hit(wr_en, addr, `REG_SLOW_CONTROL)) begin
        slow_control_state <= wd[3:0];
      end
      if (wr_hit(wr_en, addr, `REG_DATA_TAKING)) begin
        data_taking_state <= wd[3:0];
      end
    end
  end

  // software write wins over a same-cycle end of event: it starts the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pedestal_accumulator_state <= readout_pkg::ped_standby;
    end else if (wr_hit(wr_en, addr, `REG_PEDESTAL)) begin
      pedestal_accumulator_state <= wd[0];
    end else if (pedestal_event_done) begin
      pedestal_accumulator_state <= readout_pkg::ped_standby;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_active <= '1;
      unit_active <= '1;
    end else begin
      if (wr_hit(wr_en, addr, `REG_CARD_ACTIVE)) begin
        card_active <= wd[N_CARDS-1:0];
      end
      if (wr_hit(wr_en, addr, `REG_UNIT_ACTIVE)) begin
        unit_active <= wd[N_UNITS-1:0];
      end
    end
  end

  // ****************************************************************
  // readout watchdog
  // ****************************************************************
  logic armed;
  logic [N_CARDS-1:0] ack_seen;
  logic [N_CARDS-1:0] ack_now;
  logic [N_UNITS-1:0] busy_pending;
  logic full_ack;
  logic timer_start;
  logic timer_stop;
  logic timing;
  logic expired;
  logic timeout_error;
  logic restart_req;

  assign ack_now = ack_seen | front_end_card_ack;
  assign full_ack = armed && ((ack_now & card_active) == card_active);
  assign timer_start = full_ack;
  assign timer_stop = timing && (busy_pending == '0);
  assign timeout_error = expired && (busy_pending != '0);
  assign restart_req = wr_hit(wr_en, addr, `REG_CONTROL) && wd[`CTRL_RESTART_BIT];

  // a trigger arms collection of acks; halted acquisition arms nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      ack_seen <= '0;
    end else if (trigger_sent && !acq_halt) begin
      armed <= 1'b1;
      ack_seen <= front_end_card_ack;
    end else if (full_ack) begin
      armed <= 1'b0;
      ack_seen <= '0;
    end else if (armed) begin
      ack_seen <= ack_now;
    end
  end

  // a clear-busy arriving with the last ack is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_pending <= '0;
    end else if (timer_start) begin
      busy_pending <= unit_active & ~front_end_unit_clear_busy;
    end else begin
      busy_pending <= busy_pending & ~front_end_unit_clear_busy;
    end
  end

  readout_timer #(
    .CYCLES_PER_STEP(CYCLES_PER_STEP)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(timer_start),
    .stop(timer_stop),
    .limit(max_time),
    .running(timing),
    .expired(expired)
  );

  // expiry beats a same-cycle restart so no timeout goes unseen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_halt <= 1'b0;
    end else if (timeout_error) begin
      acq_halt <= 1'b1;
    end else if (restart_req) begin
      acq_halt <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_restart_command <= 1'b0;
    end else begin
      error_restart_command <= restart_req;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic [`IRQ_WIDTH-1:0] irq_clr;
  logic [`IRQ_WIDTH-1:0] irq_stat;
  logic [`IRQ_WIDTH-1:0] irq_mask;

  always_comb begin
    irq_set = '0;
    irq_set[`IRQ_TIMEOUT_BIT] = timeout_error;
    irq_set[`IRQ_PED_DONE_BIT] = pedestal_event_done;
    irq_clr = wr_hit(wr_en, addr, `REG_IRQ_STATUS) ? wd[`IRQ_WIDTH-1:0] : '0;
  end

  irq_status #(
    .W(`IRQ_WIDTH)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(irq_set),
    .clear_ones(irq_clr),
    .mask_we(wr_hit(wr_en, addr, `REG_IRQ_MASK)),
    .mask_wdata(wd[`IRQ_WIDTH-1:0]),
    .status(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      `REG_MAX_TIME: next_rdata[4:0] = max_time;
      `REG_IRQ_STATUS: next_rdata[`IRQ_WIDTH-1:0] = irq_stat;
      `REG_IRQ_MASK: next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
      `REG_FSM_STATES: next_rdata[23:0] = {packet_mover_state, event_builder_state,
                                           trigger_generator_state};
      `REG_SLOW_CONTROL: next_rdata[3:0] = slow_control_state;
      `REG_DATA_TAKING: next_rdata[3:0] = data_taking_state;
      `REG_PEDESTAL: next_rdata[0] = pedestal_accumulator_state;
      `REG_CARD_ACTIVE: next_rdata[N_CARDS-1:0] = card_active;
      `REG_UNIT_ACTIVE: next_rdata[N_UNITS-1:0] = unit_active;
      `REG_MONITOR: begin
        next_rdata[`MON_HALT_BIT] = acq_halt;
        next_rdata[`MON_TIMING_BIT] = timing;
        next_rdata[`MON_ARMED_BIT] = armed;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // data is caught in the cycle before pready, held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_take) begin
      prdata <= next_rdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_fsm_read;
    rd_take && addr == `REG_FSM_STATES;
  endsequence

  sequence s_restart_clean;
    restart_req && !timeout_error;
  endsequence

  chk_limit_range: assert property (@(posedge pclk) disable iff (!presetn)
    max_time <= `MAX_TIME_LIMIT) else $error("readout limit out of range");

  chk_start_times: assert property (@(posedge pclk) disable iff (!presetn)
    timer_start |=> timing) else $error("full ack did not start timing");

  chk_release_stops: assert property (@(posedge pclk) disable iff (!presetn)
    timing && busy_pending == '0 && !timer_start |=> !timing)
    else $error("timer kept running after release");

  chk_halt_on_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    timeout_error |=> acq_halt && irq_stat[`IRQ_TIMEOUT_BIT])
    else $error("timeout did not halt");

  chk_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
    acq_halt && !restart_req |=> acq_halt) else $error("halt dropped without restart");

  chk_restart_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_restart_clean |=> !acq_halt ##0 error_restart_command)
    else $error("restart did not clear error");

  chk_states_readback: assert property (@(posedge pclk) disable iff (!presetn)
    s_fsm_read |=> pready && prdata[23:0] == $past({packet_mover_state,
      event_builder_state, trigger_generator_state}))
    else $error("state readback mismatch");

  chk_pedestal_done: assert property (@(posedge pclk) disable iff (!presetn)
    pedestal_event_done && !wr_hit(wr_en, addr, `REG_PEDESTAL)
    |=> pedestal_accumulator_state == readout_pkg::ped_standby)
    else $error("pedestal not back to standby");

  chk_state_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit(wr_en, addr, `REG_SLOW_CONTROL) |=> slow_control_state == $past(wd[3:0]))
    else $error("slow-control write lost");

  chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && apb_req.penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

endmodule
`default_nettype wire

/* File: testbench/front_end_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// front-end cards and units answering each trigger
// ****************************************************************
module front_end_model #(
  parameter int N_CARDS = 4,
  parameter int N_UNITS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger_sent,
  input wire logic [7:0] ack_delay,
  input wire logic [7:0] busy_delay,
  input wire logic [N_UNITS-1:0] stuck,
  output logic [N_CARDS-1:0] card_ack,
  output logic [N_UNITS-1:0] clear_busy
);
  logic [8:0] age;
  logic live;
  logic [8:0] done_at;

  assign done_at = {1'b0, ack_delay} + {1'b0, busy_delay};

  // age counts cycles since the last trigger; a new trigger rearms at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= 9'h000;
      live <= 1'b0;
    end else if (trigger_sent) begin
      age <= 9'h000;
      live <= 1'b1;
    end else if (live) begin
      age <= age + 9'h001;
      if (age == done_at) begin
        live <= 1'b0;
      end
    end
  end

  // one-cycle pulses; a stuck unit never clears, as a broken unit would
  assign card_ack = (live && age == {1'b0, ack_delay}) ? '1 : '0;
  assign clear_busy = (live && age == done_at) ? ~stuck : '0;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "readout_supervisor_regs.svh"
module testbench;
  localparam int T1 = 20; // (1 + 1) steps of 10 cycles
  logic pclk;
  logic presetn;
  readout_pkg::apb_req_s req;
  logic pready, pslverr, acq_halt, restart_pulse, irq, trigger_sent, ped_done;
  logic [31:0] prdata;
  logic [7:0] gen_state, builder_state, mover_state, ack_delay, busy_delay;
  logic [3:0] stuck, card_ack, clear_busy;
  int err_count;
  int compares;

  readout_timeout_state_supervisor #(.N_CARDS(4), .N_UNITS(4), .CYCLES_PER_STEP(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trigger_sent(trigger_sent), .front_end_card_ack(card_ack),
    .front_end_unit_clear_busy(clear_busy), .pedestal_event_done(ped_done),
    .trigger_generator_state(gen_state), .event_builder_state(builder_state),
    .packet_mover_state(mover_state),
    .acq_halt(acq_halt), .error_restart_command(restart_pulse), .irq(irq));

  front_end_model #(.N_CARDS(4), .N_UNITS(4)) model_u (
    .pclk(pclk), .presetn(presetn), .trigger_sent(trigger_sent), .ack_delay(ack_delay),
    .busy_delay(busy_delay), .stuck(stuck), .card_ack(card_ack), .clear_busy(clear_busy));

  // ****************************************************************
  // compares, bus cycles and pulses
  // ****************************************************************
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // holds the request until pready is sampled; reads go by at the same edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    // waits as long as it takes; only the watchdog ends a hung access
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check_bit("pready_wait", 1'b1, n == 2);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    @(posedge pclk); // let the write's side effects land
  endtask

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check_word(what, exp, r);
  endtask

  task automatic fire();
    @(posedge pclk);
    trigger_sent <= 1'b1;
    @(posedge pclk);
    trigger_sent <= 1'b0;
  endtask

  // cycles from the full card ack to the halt; 999 if it never comes
  task automatic time_to_halt(output int n);
    int k;
    k = 0;
    while (card_ack[0] !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    n = 0;
    while (acq_halt !== 1'b1 && n < 999) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd_check("max_time", `REG_MAX_TIME, 32'h10);
    rd_check("slow_control", `REG_SLOW_CONTROL, 32'h0);
    rd_check("data_taking", `REG_DATA_TAKING, 32'h0);
    rd_check("pedestal", `REG_PEDESTAL, 32'h0);
    rd_check("irq_status", `REG_IRQ_STATUS, 32'h0);
    rd_check("card_active", `REG_CARD_ACTIVE, 32'hf);
    apb(1'b0, 8'h2c, 32'h0, r, e);
    check_bit("unmapped_err", 1'b1, e);
    check_word("unmapped_data", 32'h0, r);
    $display("test reset done");
  endtask

  task automatic t_states();
    for (int i = 0; i < 6; i++) begin
      wr(`REG_SLOW_CONTROL, 32'(i));
      rd_check("slow_control", `REG_SLOW_CONTROL, 32'(i));
    end
    // slow control now reads 0x5, monitor_paused_c; data-taking writes do not depend on it
    for (int i = 0; i < 9; i++) begin
      wr(`REG_DATA_TAKING, 32'(i));
      rd_check("data_taking", `REG_DATA_TAKING, 32'(i));
    end
    wr(`REG_PEDESTAL, 32'h1);
    rd_check("pedestal", `REG_PEDESTAL, 32'h1);
    wr(`REG_MAX_TIME, 32'h0);
    rd_check("max_time", `REG_MAX_TIME, 32'h0);
    wr(`REG_MAX_TIME, 32'h1f);
    rd_check("max_time", `REG_MAX_TIME, 32'h10);
    $display("test states done");
  endtask

  task automatic t_readonly();
    @(posedge pclk);
    gen_state <= 8'h5a;
    builder_state <= 8'hc3;
    mover_state <= 8'h81;
    rd_check("fsm_states", `REG_FSM_STATES, 32'h0081c35a);
    wr(`REG_FSM_STATES, 32'hffffffff);
    rd_check("fsm_states", `REG_FSM_STATES, 32'h0081c35a);
    $display("test readonly done");
  endtask

  // trigger to release is 14 cycles, ack to release only 6, limit 10
  task automatic t_readout();
    wr(`REG_MAX_TIME, 32'h0);
    ack_delay <= 8'h08;
    busy_delay <= 8'h06;
    stuck <= 4'h0;
    fire();
    repeat (40) @(posedge pclk);
    check_bit("acq_halt", 1'b0, acq_halt);
    rd_check("irq_status", `REG_IRQ_STATUS, 32'h0);
    $display("test readout done");
  endtask

  task automatic t_timeout();
    int n;
    logic seen;
    wr(`REG_MAX_TIME, 32'h1);
    wr(`REG_IRQ_MASK, 32'h1);
    ack_delay <= 8'h02;
    busy_delay <= 8'h01;
    stuck <= 4'h4;
    fire();
    time_to_halt(n);
    check_bit("halt_delay", 1'b1, n >= T1 && n <= T1 + 4);
    rd_check("monitor", `REG_MONITOR, 32'h1);
    rd_check("irq_status", `REG_IRQ_STATUS, 32'h1);
    check_bit("irq", 1'b1, irq);
    wr(`REG_IRQ_STATUS, 32'h1);
    check_bit("irq", 1'b0, irq);
    check_bit("acq_halt", 1'b1, acq_halt);
    wr(`REG_CONTROL, 32'h1);
    seen = restart_pulse;
    repeat (3) begin
      @(posedge pclk);
      seen = seen | restart_pulse;
    end
    check_bit("restart_pulse", 1'b1, seen);
    check_bit("acq_halt", 1'b0, acq_halt);
    $display("test timeout done");
  endtask

  // a second full ack must restart the count; halting now shows resumed timing
  task automatic t_retrigger();
    int n;
    fire();
    repeat (12) @(posedge pclk);
    check_bit("acq_halt", 1'b0, acq_halt);
    fire();
    time_to_halt(n);
    check_bit("halt_delay", 1'b1, n >= T1 && n <= T1 + 4);
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_IRQ_STATUS, 32'h1);
    check_bit("acq_halt", 1'b0, acq_halt);
    $display("test retrigger done");
  endtask

  task automatic t_pedestal();
    logic [31:0] r;
    logic e;
    int k;
    wr(`REG_IRQ_MASK, 32'h0);
    wr(`REG_PEDESTAL, 32'h1);
    @(posedge pclk);
    ped_done <= 1'b1;
    @(posedge pclk);
    ped_done <= 1'b0;
    k = 0;
    do begin
      apb(1'b0, `REG_PEDESTAL, 32'h0, r, e);
      k++;
    end while (r !== 32'h0 && k < 10);
    check_word("pedestal", 32'h0, r);
    rd_check("irq_status", `REG_IRQ_STATUS, 32'h2);
    check_bit("irq_masked", 1'b0, irq);
    wr(`REG_IRQ_MASK, 32'h2);
    check_bit("irq", 1'b1, irq);
    wr(`REG_IRQ_STATUS, 32'h2);
    check_bit("irq", 1'b0, irq);
    $display("test pedestal done");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // the whole run needs about 400 cycles; 10000 means a hang
  initial begin
    #100us;
    err_count++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    trigger_sent = 1'b0;
    ped_done = 1'b0;
    gen_state = 8'h00;
    builder_state = 8'h00;
    mover_state = 8'h00;
    ack_delay = 8'h02;
    busy_delay = 8'h01;
    stuck = 4'h0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_states();
    t_readonly();
    t_readout();
    t_timeout();
    t_retrigger();
    t_pedestal();
    test_done();
  end
endmodule
`default_nettype wire
